// ==== rtl/dtd_defines.svh ====
// Constants of the drive I/O terminal decoder.
// Included by the package and by the top module; definitions only.
`ifndef DTD_DEFINES_SVH
`define DTD_DEFINES_SVH
// Analog scales: centivolts and tenths of a percent
`define DTD_FULL_CV 10'd1000
`define DTD_PCT_MAX 12'sd1000
`define DTD_TAU_MIN 6'd1
`define DTD_TAU_MAX 6'd50
`define DTD_TICKS_PER_TAU 13'd100
// Filter tick timing
`define DTD_CLK_NS 10
`define DTD_TICK_MS 1
`define DTD_TICK_CYC (`DTD_TICK_MS * 1000000 / `DTD_CLK_NS)
`define DTD_TICK_MAX 1048575
`define DTD_AO_SHIFT 16
// Register byte offsets
`define DTD_A_AI_RANGE 8'h00
`define DTD_A_AI_SET 8'h04
`define DTD_A_AI_FILT 8'h08
`define DTD_A_AO_SEL 8'h0c
`define DTD_A_AO_LIM 8'h10
`define DTD_A_DI_FUNC 8'h14
`define DTD_A_CTRL 8'h18
`define DTD_A_STATUS 8'h1c
`define DTD_A_AI_VAL 8'h20
`define DTD_A_COUNT 8'h24
// Field positions
`define DTD_LO 9:0
`define DTD_HI 25:16
`define DTD_PLO 11:0
`define DTD_PHI 27:16
`define DTD_TAU 5:0
`define DTD_AOS 2:0
`define DTD_DIF 24:0
`define DTD_RSRC 1:0
`define DTD_FSRC 5:4
`define DTD_CDN 8
`define DTD_DIL 4:0
`define DTD_FLT 8
`define DTD_STG 18:16
`define DTD_CH 21:20
`define DTD_CNT 15:0
// Reset values
`define DTD_RST_DEV 10'd10
`define DTD_RST_DI_FUNC 25'h0000083
`define DTD_RST_RUN_SRC 2'd0
`define DTD_RST_FSRC 2'd0
// Terminal count and function code width
`define DTD_NTERM 5
`define DTD_FN_W 5
// Terminal function codes
`define DTD_FN_JOG_FWD 1
`define DTD_FN_JOG_REV 2
`define DTD_FN_RUN_FWD 3
`define DTD_FN_RUN_REV 4
`define DTD_FN_3WIRE 5
`define DTD_FN_COAST 6
`define DTD_FN_STOP 7
`define DTD_FN_RESET 8
`define DTD_FN_EXT_FLT 9
`define DTD_FN_UP 10
`define DTD_FN_DOWN 11
`define DTD_FN_S1 13
`define DTD_FN_S2 14
`define DTD_FN_S3 15
`define DTD_FN_F_TERM 16
`define DTD_FN_F_COMM 17
`define DTD_FN_DCB 18
`define DTD_FN_SW_AI 19
`define DTD_FN_SW_D1 20
`define DTD_FN_SW_D2 21
`define DTD_FN_CNT_CLR 23
`define DTD_FN_CNT_TRIG 24
// Run command channels and frequency sources
`define DTD_RUN_TERM 2'd1
`define DTD_RUN_COMM 2'd2
`define DTD_FS_DIG1 2'd0
`define DTD_FS_DIG2 2'd1
`define DTD_FS_AI 2'd2
// Analog output sources
`define DTD_AO_FREQ 3'd0
`define DTD_AO_CUR 3'd1
`define DTD_AO_SPD 3'd2
`define DTD_AO_VOLT 3'd3
`define DTD_AO_AI 3'd4
// AXI responses
`define DTD_OKAY 2'b00
`define DTD_SLVERR 2'b10
`endif

// ==== rtl/dtd_pkg.sv ====
// Types of the drive I/O terminal decoder.
// Needs dtd_defines.svh on the include path.
package dtd_pkg;
`include "dtd_defines.svh"

	// Commands towards the run and frequency control logic
	typedef struct packed {
		logic jog_fwd;
		logic jog_rev;
		logic run_forward;
		logic run_reverse;
		logic three_wire_stop;
		logic coast_stop;
		logic decel_stop;
		logic fault_reset;
		logic freq_up;
		logic freq_down;
		logic dc_brake;
		logic counter_clear;
		logic [2:0] stage_sel;
		logic [1:0] run_channel;
		logic [1:0] freq_source;
	} dtd_cmd_t;

	// Whole state of the top module
	typedef struct packed {
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic [2:0] edge_q;
		logic [19:0] tick;
		logic [22:0] acc;
		logic [9:0] filt;
		logic [9:0] held;
		logic signed [11:0] pct;
		logic [9:0] ao;
		logic [9:0] ai_lo;
		logic [9:0] ai_hi;
		logic signed [11:0] p_lo;
		logic signed [11:0] p_hi;
		logic [5:0] tau;
		logic [9:0] dev;
		logic [2:0] ao_sel;
		logic [9:0] ao_lo;
		logic [9:0] ao_hi;
		logic [24:0] di_func;
		logic [1:0] run_src;
		logic [1:0] freq_src;
		logic cnt_down;
		logic fault;
		logic [15:0] count;
		dtd_cmd_t cmd;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} dtd_state_t;
endpackage

// ==== rtl/dtd_top.sv ====
// Drive I/O terminal decoder: analog input conditioning, analog output
// selection and decoding of five digital input terminals into commands.
// Assumes inputs synchronous to i_clk and an AXI4-Lite master.
//
// Summary of operation
// - Analog input between limits maps linearly onto +-100% endpoints.
// - Analog input low-pass filtered, time constant 0.1 s to 5 s.
// - Analog changes below the deviation limit are ignored.
// - In current mode 0..20 mA counts as 0..10 V.
// - Analog output source chosen by code 0 to 4.
// - Analog output clamped between lower and upper output limits.
// - Each terminal has a function code 0..30, defaults 3, 4, 0.
// - Jog terminals act only when run channel is terminal.
// - Codes 3 and 4 run forward or reverse, terminal channel only.
// - Code 7 commands a decelerating stop.
// - Code 8 clears an active fault on any channel.
// - Code 9 raises the external fault alarm.
// - Codes 10 and 11 step frequency only on up/down source.
// - Codes 13 to 15 form a three-bit stage select.
// - Code 16 forces terminal run channel while held.
// - Code 17 forces communication run channel while held.
// - Code 18 becoming active enters DC braking.
// - Codes 19 to 21 switch frequency source while held.
// - Code 6 commands a coast stop.
// - Code 5 is the three-wire stop line.
// - Code 23 clears the event counter.
// - Counter trigger steps the counter once per pulse, up or down.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "dtd_defines.svh"

module dtd_top
	import dtd_pkg::*;
#(
	// Clock cycles per 1 ms filter tick
	parameter int TICK_CYCLES = `DTD_TICK_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// AXI4-Lite write
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	// Analog input, hundredths of a volt or milliamp
	input wire logic [10:0] i_analog_in,
	input wire logic i_input_type_jumper,
	// Analog output sources, fraction of full scale
	input wire logic [15:0] i_out_freq,
	input wire logic [15:0] i_out_current,
	input wire logic [15:0] i_motor_speed,
	input wire logic [15:0] i_out_voltage,
	// Digital terminals, active low
	input wire logic [4:0] i_digital_in,
	// Results
	output dtd_cmd_t o_cmd,
	output logic o_external_fault_alarm,
	output logic signed [11:0] o_ai_setting,
	output logic [9:0] o_analog_out,
	output logic [15:0] o_event_count
);

	localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

	if (TICK_CYCLES < 1 || TICK_CYCLES > `DTD_TICK_MAX) begin : g_bad
		$error("TICK_CYCLES out of range");
	end

	dtd_state_t s;
	dtd_state_t next_s;
	logic [4:0] act;
	logic [31:0] fn;
	logic [31:0] fn_or [`DTD_NTERM+1];
	logic [1:0] ch_eff;
	logic [1:0] fs_eff;
	logic [9:0] db_diff;
	logic aw_take;
	logic w_take;
	logic ar_take;

	assign act = ~s.sync2;
	assign fn_or[0] = '0;

	// Each terminal sets the bit of its function code while active
	for (genvar t = 0; t < `DTD_NTERM; t++) begin : g_term
		logic [4:0] code;
		assign code = s.di_func[t*`DTD_FN_W +: `DTD_FN_W];
		assign fn_or[t+1] = fn_or[t] |
			(act[t] ? (32'h1 << code) : 32'h0);
	end
	// Codes 0, 12, 22 and above 24 are never read
	assign fn = fn_or[`DTD_NTERM];

	// Forcing terminal wins over forcing communication
	assign ch_eff = fn[`DTD_FN_F_TERM] ? `DTD_RUN_TERM :
		fn[`DTD_FN_F_COMM] ? `DTD_RUN_COMM : s.run_src;
	assign fs_eff = fn[`DTD_FN_SW_AI] ? `DTD_FS_AI :
		fn[`DTD_FN_SW_D1] ? `DTD_FS_DIG1 :
		fn[`DTD_FN_SW_D2] ? `DTD_FS_DIG2 : s.freq_src;
	assign db_diff = (s.filt > s.held) ? s.filt - s.held :
		s.held - s.filt;

	assign o_s_axi_awready = ~s.aw_got & ~s.bvalid;
	assign o_s_axi_wready = ~s.w_got & ~s.bvalid;
	assign o_s_axi_arready = ~s.rvalid;
	assign aw_take = i_s_axi_awvalid & o_s_axi_awready;
	assign w_take = i_s_axi_wvalid & o_s_axi_wready;
	assign ar_take = i_s_axi_arvalid & o_s_axi_arready;

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] m);
		for (int b = 0; b < 4; b++)
			if (m[b])
				o[b*8 +: 8] = d[b*8 +: 8];
		return o;
	endfunction

	function automatic logic [9:0] lim_cv(input logic [9:0] v);
		return (v > `DTD_FULL_CV) ? `DTD_FULL_CV : v;
	endfunction

	function automatic logic signed [11:0] lim_pct(
		input logic signed [11:0] p);
		if (p > `DTD_PCT_MAX)
			return `DTD_PCT_MAX;
		if (p < -`DTD_PCT_MAX)
			return -`DTD_PCT_MAX;
		return p;
	endfunction

	// Register image; valid flags whether the word is mapped
	function automatic logic [32:0] img(input logic [7:0] a,
		input dtd_state_t q, input logic [4:0] dl);
		logic [31:0] r;
		r = '0;
		unique case ({a[7:2], 2'b00})
			`DTD_A_AI_RANGE: begin
				r[`DTD_LO] = q.ai_lo;
				r[`DTD_HI] = q.ai_hi;
			end
			`DTD_A_AI_SET: begin
				r[`DTD_PLO] = q.p_lo;
				r[`DTD_PHI] = q.p_hi;
			end
			`DTD_A_AI_FILT: begin
				r[`DTD_TAU] = q.tau;
				r[`DTD_HI] = q.dev;
			end
			`DTD_A_AO_SEL: r[`DTD_AOS] = q.ao_sel;
			`DTD_A_AO_LIM: begin
				r[`DTD_LO] = q.ao_lo;
				r[`DTD_HI] = q.ao_hi;
			end
			`DTD_A_DI_FUNC: r[`DTD_DIF] = q.di_func;
			`DTD_A_CTRL: begin
				r[`DTD_RSRC] = q.run_src;
				r[`DTD_FSRC] = q.freq_src;
				r[`DTD_CDN] = q.cnt_down;
			end
			`DTD_A_STATUS: begin
				r[`DTD_DIL] = dl;
				r[`DTD_FLT] = q.fault;
				r[`DTD_STG] = q.cmd.stage_sel;
				r[`DTD_CH] = q.cmd.run_channel;
			end
			`DTD_A_AI_VAL: begin
				r[`DTD_PLO] = q.pct;
				r[`DTD_HI] = q.held;
			end
			`DTD_A_COUNT: r[`DTD_CNT] = q.count;
			default: return {1'b0, 32'h0};
		endcase
		return {1'b1, r};
	endfunction

	always_comb begin
		logic [9:0] x;
		logic [9:0] v;
		logic [9:0] cv;
		logic [12:0] ndiv;
		logic [15:0] src;
		logic signed [23:0] dv;
		logic signed [23:0] dp;
		logic signed [23:0] den;
		logic [7:0] wa;
		logic [31:0] wd;
		logic [32:0] im;
		logic do_wr;
		logic rst_p;
		logic trig;
		logic sw_clr;
		logic tau_wr;
		next_s = s;
		x = i_input_type_jumper ? i_analog_in[10:1] :
			lim_cv(i_analog_in[9:0] | {10{i_analog_in[10]}});
		v = '0;
		cv = '0;
		ndiv = 13'(s.tau * `DTD_TICKS_PER_TAU);
		src = '0;
		dv = '0;
		dp = '0;
		den = '0;
		wa = s.aw_got ? s.awaddr : i_s_axi_awaddr;
		wd = '0;
		im = '0;
		do_wr = (s.aw_got | aw_take) & (s.w_got | w_take) & ~s.bvalid;
		rst_p = fn[`DTD_FN_RESET] & ~s.edge_q[0];
		trig = fn[`DTD_FN_CNT_TRIG] & ~s.edge_q[2];
		sw_clr = 1'b0;
		tau_wr = 1'b0;

		next_s.sync1 = i_digital_in;
		next_s.sync2 = s.sync1;
		next_s.edge_q = {fn[`DTD_FN_CNT_TRIG], fn[`DTD_FN_DCB],
			fn[`DTD_FN_RESET]};

		// First-order filter, acc holds output times tau in ticks
		next_s.tick = (s.tick == TICK_LAST) ? '0 : s.tick + 20'd1;
		if (s.tick == TICK_LAST)
			next_s.acc = s.acc + 23'(x) - 23'(s.filt);
		next_s.filt = 10'(s.acc / 23'(ndiv));
		if (db_diff != '0 && db_diff >= s.dev)
			next_s.held = s.filt;

		// Linear map, held value clamped into the input window
		v = (s.held < s.ai_lo) ? s.ai_lo :
			(s.held > s.ai_hi) ? s.ai_hi : s.held;
		dv = 24'(v - s.ai_lo);
		dp = 24'(s.p_hi) - 24'(s.p_lo);
		den = 24'(s.ai_hi - s.ai_lo);
		if (s.ai_hi <= s.ai_lo)
			next_s.pct = s.p_lo;
		else
			next_s.pct = 12'(24'(s.p_lo) + (dv * dp) / den);

		case (s.ao_sel)
			`DTD_AO_FREQ: src = i_out_freq;
			`DTD_AO_CUR: src = i_out_current;
			`DTD_AO_SPD: src = i_motor_speed;
			`DTD_AO_VOLT: src = i_out_voltage;
			default: src = '0;
		endcase
		cv = 10'((26'(src) * 26'(`DTD_FULL_CV)) >> `DTD_AO_SHIFT);
		if (s.ao_sel == `DTD_AO_AI)
			cv = s.held;
		if (cv > s.ao_hi)
			cv = s.ao_hi;
		if (cv < s.ao_lo)
			cv = s.ao_lo;
		// Reserved source codes keep the last output
		if (s.ao_sel <= `DTD_AO_AI)
			next_s.ao = cv;

		// Commands; run and jog only on the terminal channel
		next_s.cmd.jog_fwd = fn[`DTD_FN_JOG_FWD] &
			(ch_eff == `DTD_RUN_TERM);
		next_s.cmd.jog_rev = fn[`DTD_FN_JOG_REV] &
			(ch_eff == `DTD_RUN_TERM);
		next_s.cmd.run_forward = fn[`DTD_FN_RUN_FWD] &
			(ch_eff == `DTD_RUN_TERM);
		next_s.cmd.run_reverse = fn[`DTD_FN_RUN_REV] &
			(ch_eff == `DTD_RUN_TERM);
		next_s.cmd.three_wire_stop = fn[`DTD_FN_3WIRE];
		next_s.cmd.coast_stop = fn[`DTD_FN_COAST];
		next_s.cmd.decel_stop = fn[`DTD_FN_STOP];
		next_s.cmd.fault_reset = rst_p;
		next_s.cmd.freq_up = fn[`DTD_FN_UP] &
			(fs_eff == `DTD_FS_DIG2);
		next_s.cmd.freq_down = fn[`DTD_FN_DOWN] &
			(fs_eff == `DTD_FS_DIG2);
		next_s.cmd.dc_brake = fn[`DTD_FN_DCB] & ~s.edge_q[1];
		next_s.cmd.counter_clear = fn[`DTD_FN_CNT_CLR];
		next_s.cmd.stage_sel = {fn[`DTD_FN_S3], fn[`DTD_FN_S2],
			fn[`DTD_FN_S1]};
		next_s.cmd.run_channel = ch_eff;
		next_s.cmd.freq_source = fs_eff;

		if (fn[`DTD_FN_CNT_CLR])
			next_s.count = '0;
		else if (trig)
			next_s.count = s.cnt_down ? s.count - 16'd1 :
				s.count + 16'd1;

		// Write channel: address and data taken in either order
		if (aw_take) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = i_s_axi_awaddr;
		end
		if (w_take) begin
			next_s.w_got = 1'b1;
			next_s.wdata = i_s_axi_wdata;
			next_s.wstrb = i_s_axi_wstrb;
		end
		if (s.bvalid && i_s_axi_bready)
			next_s.bvalid = 1'b0;
		if (do_wr) begin
			im = img(wa, s, act);
			wd = merge(im[31:0], s.w_got ? s.wdata : i_s_axi_wdata,
				s.w_got ? s.wstrb : i_s_axi_wstrb);
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = im[32] ? `DTD_OKAY : `DTD_SLVERR;
			unique case ({wa[7:2], 2'b00})
				`DTD_A_AI_RANGE: begin
					next_s.ai_lo = lim_cv(wd[`DTD_LO]);
					next_s.ai_hi = lim_cv(wd[`DTD_HI]);
				end
				`DTD_A_AI_SET: begin
					next_s.p_lo = lim_pct(wd[`DTD_PLO]);
					next_s.p_hi = lim_pct(wd[`DTD_PHI]);
				end
				`DTD_A_AI_FILT: begin
					tau_wr = 1'b1;
					next_s.tau = (wd[`DTD_TAU] < `DTD_TAU_MIN) ?
						`DTD_TAU_MIN : (wd[`DTD_TAU] > `DTD_TAU_MAX) ?
						`DTD_TAU_MAX : wd[`DTD_TAU];
					next_s.dev = lim_cv(wd[`DTD_HI]);
				end
				`DTD_A_AO_SEL: next_s.ao_sel = wd[`DTD_AOS];
				`DTD_A_AO_LIM: begin
					next_s.ao_lo = lim_cv(wd[`DTD_LO]);
					next_s.ao_hi = lim_cv(wd[`DTD_HI]);
				end
				`DTD_A_DI_FUNC: next_s.di_func = wd[`DTD_DIF];
				`DTD_A_CTRL: begin
					next_s.run_src = wd[`DTD_RSRC];
					next_s.freq_src = wd[`DTD_FSRC];
					next_s.cnt_down = wd[`DTD_CDN];
				end
				`DTD_A_STATUS: sw_clr = wd[`DTD_FLT] &
					(s.w_got ? s.wstrb[1] : i_s_axi_wstrb[1]);
				default: ;
			endcase
		end
		// Rescale the accumulator so the output does not jump
		if (tau_wr)
			next_s.acc = 23'(s.filt) * 23'(next_s.tau) *
				23'(`DTD_TICKS_PER_TAU);

		// A new fault in the clearing cycle still sets the flag
		next_s.fault = (s.fault & ~(rst_p | sw_clr)) |
			fn[`DTD_FN_EXT_FLT];

		if (s.rvalid && i_s_axi_rready)
			next_s.rvalid = 1'b0;
		if (ar_take) begin
			im = img(i_s_axi_araddr, s, act);
			next_s.rvalid = 1'b1;
			next_s.rdata = im[31:0];
			next_s.rresp = im[32] ? `DTD_OKAY : `DTD_SLVERR;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s <= '0;
			s.sync1 <= 5'h1f;
			s.sync2 <= 5'h1f;
			s.ai_hi <= `DTD_FULL_CV;
			s.p_hi <= `DTD_PCT_MAX;
			s.tau <= `DTD_TAU_MIN;
			s.dev <= `DTD_RST_DEV;
			s.ao_hi <= `DTD_FULL_CV;
			s.di_func <= `DTD_RST_DI_FUNC;
			s.run_src <= `DTD_RST_RUN_SRC;
			s.freq_src <= `DTD_RST_FSRC;
		end else begin
			s <= next_s;
		end
	end

	assign o_s_axi_bresp = s.bresp;
	assign o_s_axi_bvalid = s.bvalid;
	assign o_s_axi_rdata = s.rdata;
	assign o_s_axi_rresp = s.rresp;
	assign o_s_axi_rvalid = s.rvalid;
	assign o_cmd = s.cmd;
	assign o_external_fault_alarm = s.fault;
	assign o_ai_setting = s.pct;
	assign o_analog_out = s.ao;
	assign o_event_count = s.count;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	property p_ai_low_end;
		(s.ai_hi > s.ai_lo && s.held <= s.ai_lo) |=>
			(s.pct == $past(s.p_lo));
	endproperty
	a_ai_low_end: assert property (p_ai_low_end)
		else $error("setting not at lower endpoint");

	property p_tau_range;
		s.tau >= `DTD_TAU_MIN && s.tau <= `DTD_TAU_MAX;
	endproperty
	a_tau_range: assert property (p_tau_range)
		else $error("filter time constant out of range");

	property p_deadband;
		$changed(s.held) |-> $past(db_diff) >= $past(s.dev);
	endproperty
	a_deadband: assert property (p_deadband)
		else $error("held value moved inside deviation limit");

	property p_ao_clamp;
		(s.ao_sel <= `DTD_AO_AI && s.ao_lo <= s.ao_hi) |=>
			(o_analog_out >= $past(s.ao_lo) &&
			o_analog_out <= $past(s.ao_hi));
	endproperty
	a_ao_clamp: assert property (p_ao_clamp)
		else $error("analog output outside limits");

	property p_ao_reserved;
		(s.ao_sel > `DTD_AO_AI) |=> $stable(o_analog_out);
	endproperty
	a_ao_reserved: assert property (p_ao_reserved)
		else $error("reserved output code changed output");

	property p_run_gate;
		(o_cmd.run_forward || o_cmd.jog_fwd) |->
			$past(ch_eff) == `DTD_RUN_TERM;
	endproperty
	a_run_gate: assert property (p_run_gate)
		else $error("run command outside terminal channel");

	property p_sync;
		!i_digital_in[0] ##1 !i_digital_in[0] |=> act[0];
	endproperty
	a_sync: assert property (p_sync)
		else $error("terminal not active two cycles after low");

	property p_fault_set;
		fn[`DTD_FN_EXT_FLT] |=> o_external_fault_alarm;
	endproperty
	a_fault_set: assert property (p_fault_set)
		else $error("external fault not raised");

	property p_fault_clr;
		(o_external_fault_alarm && fn[`DTD_FN_RESET] && !s.edge_q[0] &&
			!fn[`DTD_FN_EXT_FLT]) |=> !o_external_fault_alarm;
	endproperty
	a_fault_clr: assert property (p_fault_clr)
		else $error("reset terminal did not clear fault");

	property p_count_step;
		(fn[`DTD_FN_CNT_TRIG] && !s.edge_q[2] && !fn[`DTD_FN_CNT_CLR] &&
			!s.cnt_down) |=> o_event_count == $past(o_event_count) + 16'd1;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter did not step up");

	property p_force_term;
		fn[`DTD_FN_F_TERM] |=> o_cmd.run_channel == `DTD_RUN_TERM;
	endproperty
	a_force_term: assert property (p_force_term)
		else $error("run channel not forced to terminal");

	c_fault: cover property (fn[`DTD_FN_EXT_FLT] ##1 o_cmd.fault_reset);
	c_stage7: cover property (o_cmd.stage_sel == 3'h7);
	c_count: cover property (o_event_count == 16'h2);
	c_clamp: cover property (s.ao_sel == `DTD_AO_FREQ &&
		o_analog_out == s.ao_hi && s.ao_hi != `DTD_FULL_CV);

endmodule // dtd_top

// ==== tb/dtd_field.sv ====
// Field side model: switches to ground and an analog sensor.
// Assumes the bench names the closed switches and the sensor level.
`timescale 1ns/1ps
module dtd_field (
	// Bench side
	input wire logic i_clk,
	input wire logic [4:0] i_closed,
	input wire logic [10:0] i_level,
	// Terminal side
	output logic [4:0] o_digital_in,
	output logic [10:0] o_analog_in
);
	// Open contacts rest at the pull-up level
	initial begin
		o_digital_in = 5'h1f;
		o_analog_in = 11'h000;
		forever @(posedge i_clk) begin
			o_digital_in <= ~i_closed;
			o_analog_in <= i_level;
		end
	end
endmodule // dtd_field

// ==== tb/drive_io_terminal_decoder_test.sv ====
// Self-checking bench of the drive I/O terminal decoder.
// Assumes dtd_pkg compiled first; short filter tick for speed.
`timescale 1ns/1ps
module drive_io_terminal_decoder_test import dtd_pkg::*;;
	logic i_clk, i_resetn, i_s_axi_awvalid, i_s_axi_wvalid;
	logic i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
	logic i_input_type_jumper, o_s_axi_awready, o_s_axi_wready;
	logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	logic o_external_fault_alarm, fr_seen, dcb_seen;
	logic [7:0] i_s_axi_awaddr, i_s_axi_araddr;
	logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rd_val;
	logic [3:0] i_s_axi_wstrb;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rsp;
	logic [10:0] i_analog_in, level;
	logic [15:0] i_out_freq, i_out_current, i_motor_speed;
	logic [15:0] i_out_voltage, o_event_count;
	logic [4:0] i_digital_in, closed;
	dtd_cmd_t o_cmd, e;
	logic signed [11:0] o_ai_setting;
	logic [9:0] o_analog_out;
	int fails, samples_checked, x, slot;
	logic [15:0] src [4];

	dtd_top #(.TICK_CYCLES(4)) u_dut (.i_clk, .i_resetn,
		.i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
		.i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
		.o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
		.i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
		.o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
		.i_analog_in, .i_input_type_jumper, .i_out_freq, .i_out_current,
		.i_motor_speed, .i_out_voltage, .i_digital_in, .o_cmd,
		.o_external_fault_alarm, .o_ai_setting, .o_analog_out,
		.o_event_count);
	dtd_field u_field (.i_clk, .i_closed(closed), .i_level(level),
		.o_digital_in(i_digital_in), .o_analog_in(i_analog_in));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Handshake flags read at the falling edge, where inputs are settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		bh = 1'b0;
		@(posedge i_clk);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wvalid <= 1'b1;
		i_s_axi_bready <= 1'b1;
		for (int n = 0; n < 50 && !bh; n++) begin
			@(negedge i_clk);
			ah = i_s_axi_awvalid && o_s_axi_awready;
			wh = i_s_axi_wvalid && o_s_axi_wready;
			bh = o_s_axi_bvalid;
			rsp = o_s_axi_bresp;
			@(posedge i_clk);
			if (ah) i_s_axi_awvalid <= 1'b0;
			if (wh) i_s_axi_wvalid <= 1'b0;
			if (bh) i_s_axi_bready <= 1'b0;
		end
		if (!bh) begin
			fails++;
			finish_test();
		end
	endtask

	task automatic rd(input logic [7:0] a);
		logic ah, h;
		h = 1'b0;
		@(posedge i_clk);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'b1;
		i_s_axi_rready <= 1'b1;
		for (int n = 0; n < 50 && !h; n++) begin
			@(negedge i_clk);
			ah = i_s_axi_arvalid && o_s_axi_arready;
			h = o_s_axi_rvalid;
			rd_val = o_s_axi_rdata;
			rsp = o_s_axi_rresp;
			@(posedge i_clk);
			if (ah) i_s_axi_arvalid <= 1'b0;
			if (h) i_s_axi_rready <= 1'b0;
		end
		if (!h) begin
			fails++;
			finish_test();
		end
	endtask

	// Closes switches, catching one-cycle pulses on the way
	task automatic press(input logic [4:0] t);
		fr_seen = 1'b0;
		dcb_seen = 1'b0;
		@(posedge i_clk);
		closed <= t;
		repeat (8) begin
			@(negedge i_clk);
			fr_seen = fr_seen | o_cmd.fault_reset;
			dcb_seen = dcb_seen | o_cmd.dc_brake;
		end
	endtask

	task automatic rel();
		@(posedge i_clk);
		closed <= 5'h00;
		repeat (6) @(negedge i_clk);
	endtask

	// Terminal channel and up/down source selected before the call
	function automatic dtd_cmd_t exp_cmd(input int c);
		dtd_cmd_t r;
		r = '0;
		r.run_channel = (c == 17) ? 2'd2 : 2'd1;
		r.freq_source = 2'd1;
		case (c)
			1: r.jog_fwd = 1'b1;
			2: r.jog_rev = 1'b1;
			3: r.run_forward = 1'b1;
			4: r.run_reverse = 1'b1;
			5: r.three_wire_stop = 1'b1;
			6: r.coast_stop = 1'b1;
			7: r.decel_stop = 1'b1;
			8: r.fault_reset = 1'b1;
			10: r.freq_up = 1'b1;
			11: r.freq_down = 1'b1;
			13: r.stage_sel = 3'h1;
			14: r.stage_sel = 3'h2;
			15: r.stage_sel = 3'h4;
			18: r.dc_brake = 1'b1;
			19: r.freq_source = 2'd2;
			20: r.freq_source = 2'd0;
			23: r.counter_clear = 1'b1;
			default: r.freq_source = 2'd1;
		endcase
		return r;
	endfunction

	// Full scale 65536 is 1000 cV, then the 100..600 window set below
	function automatic int exp_ao(input logic [15:0] v);
		int r;
		r = (int'(v) * 1000) >> 16;
		return (r > 600) ? 600 : (r < 100) ? 100 : r;
	endfunction

	task automatic settle(input int v);
		for (int n = 0; n < 20000 && o_ai_setting !== 12'(v); n++)
			@(negedge i_clk);
	endtask

	initial begin
		void'($urandom(13672));
		{i_resetn, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = '0;
		{i_s_axi_arvalid, i_s_axi_rready, i_input_type_jumper} = '0;
		{i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '0;
		i_s_axi_wstrb = 4'hf;
		{i_out_freq, i_out_current, i_motor_speed, i_out_voltage} = '0;
		closed = 5'h00;
		level = 11'h000;
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(negedge i_clk);
		chk(32'(o_cmd), 32'h0);
		rd(8'h14);
		chk(rd_val, 32'h00000083);
		rd(8'h08);
		chk(rd_val, 32'h000a0001);
		rd(8'h10);
		chk(rd_val, 32'h03e80000);
		rd(8'h80);
		chk(32'(rsp), 32'h2);
		press(5'h01);
		chk(32'(o_cmd.run_forward), 32'h0);
		wr(8'h14, 32'h00004083);
		press(5'h05);
		chk(32'({o_cmd.run_forward, o_cmd.run_channel}), 32'h5);
		rel();
		chk(32'(o_cmd.run_channel), 32'h0);
		wr(8'h18, 32'h00000011);
		for (int c = 0; c < 31; c++) begin
			slot = 2 + $urandom % 3;
			wr(8'h14, 32'h83 | (32'(c) << (5 * slot)));
			press(5'h01 << slot);
			e = exp_cmd(c);
			chk(32'({fr_seen, dcb_seen}), 32'({e.fault_reset, e.dc_brake}));
			e.fault_reset = 1'b0;
			e.dc_brake = 1'b0;
			chk(32'(o_cmd), 32'(e));
			rel();
		end
		chk(32'({o_external_fault_alarm, o_event_count}), 32'h10001);
		wr(8'h1c, 32'h00000000);
		chk(32'({o_external_fault_alarm, rsp}), 32'h4);
		wr(8'h18, 32'h00000000);
		wr(8'h14, 32'h00045c83);
		press(5'h0c);
		chk(32'({o_external_fault_alarm, o_event_count}), 32'h0);
		rel();
		wr(8'h04, 32'h03e8fc18);
		wr(8'h08, 32'h00000001);
		wr(8'h10, 32'h02580064);
		for (int j = 0; j < 2; j++) begin
			@(posedge i_clk);
			x = 600 + $urandom % 401;
			i_input_type_jumper <= j[0];
			level <= 11'(x << j);
			settle(2 * x - 1000);
			chk(32'(o_ai_setting), 32'(2 * x - 1000));
		end
		wr(8'h08, 32'h03e80001);
		level <= 11'(2 * x - 1000);
		src = '{16'h4000, 16'hffff, 16'($urandom), 16'h0000};
		{i_out_freq, i_out_current, i_motor_speed, i_out_voltage} <=
			{src[0], src[1], src[2], src[3]};
		repeat (3000) @(negedge i_clk);
		chk(32'(o_ai_setting), 32'(2 * x - 1000));
		for (int s = 4; s >= 0; s--) begin
			wr(8'h0c, 32'(s));
			repeat (4) @(negedge i_clk);
			x = (s == 4) ? 600 : exp_ao(src[2'(s)]);
			chk(32'(o_analog_out), 32'(x));
		end
		wr(8'h0c, 32'h00000005);
		i_out_freq <= 16'hffff;
		repeat (6) @(negedge i_clk);
		chk(32'(o_analog_out), 32'(x));
		finish_test();
	end
endmodule // drive_io_terminal_decoder_test
